// file: rtl/nvmac_regs.svh
// Register offsets, field positions and timing counts of the access unit
`ifndef NVMAC_REGS_SVH
`define NVMAC_REGS_SVH
`define NVMAC_OFS_ADDR_HIGH 2'h0
`define NVMAC_OFS_ADDR_LOW 2'h1
`define NVMAC_OFS_DATA 2'h2
`define NVMAC_OFS_CONTROL 2'h3
`define NVMAC_BIT_READ 0
`define NVMAC_BIT_WRITE 1
`define NVMAC_BIT_ARM 2
`define NVMAC_BIT_RIE 3
`define NVMAC_ADDR_HIGH_BITS 2
`define NVMAC_ARM_CYCLES 3'h4
`define NVMAC_WRITE_STALL 3'h2
`define NVMAC_READ_STALL 3'h4
`define NVMAC_WRITE_RC_CYCLES 14'h2100
`define NVMAC_RC_HZ 1000000
`define NVMAC_CORE_HZ 100000000
`endif

// file: rtl/nvmac_pkg.sv
// Types shared by the access unit files
`default_nettype none
package nvmac_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } nvmac_bus_req_t;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic we;
  } nvmac_array_req_t;
  typedef enum logic [2:0] {
    NVMAC_IDLE = 3'b001,
    NVMAC_WRITING = 3'b010,
    NVMAC_DONE = 3'b100
  } nvmac_state_t;
endpackage : nvmac_pkg
`default_nettype wire

// file: rtl/nvmac_rc_tick.sv
// Divider making the 1 MHz timing enable from the core clock
`include "nvmac_regs.svh"
`default_nettype none
module nvmac_rc_tick #(
  parameter int unsigned DIV = `NVMAC_CORE_HZ / `NVMAC_RC_HZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Enable pulse
  output logic tick
);
  logic [$clog2(DIV)-1:0] count;
  wire wrap = (count == ($clog2(DIV))'(DIV - 1));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= wrap ? '0 : count + 1'b1;
    end
  end
  assign tick = wrap;
endmodule : nvmac_rc_tick
`default_nettype wire

// file: rtl/nvmac_unit.sv
// Access unit for the 1024-byte data nonvolatile array
`include "nvmac_regs.svh"
`default_nettype none
module nvmac_unit
  import nvmac_pkg::*;
#(
  parameter int unsigned WRITE_RC_CYCLES = `NVMAC_WRITE_RC_CYCLES,
  parameter int unsigned RC_DIV = `NVMAC_CORE_HZ / `NVMAC_RC_HZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Processor register port
  input wire nvmac_pkg::nvmac_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Processor status
  input wire logic global_irq_enable,
  input wire logic self_program_enable,
  // Processor control
  output logic cpu_stall,
  output logic ready_irq
);
  import nvmac_pkg::*;

  // ==========================================================
  // Storage and registers
  logic [7:0] mem [0:1023];
  logic [`NVMAC_ADDR_HIGH_BITS-1:0] nvm_address_high;
  logic [7:0] nvm_address_low;
  logic [7:0] nvm_data_byte;
  logic ready_irq_enable;
  logic master_write_arm;
  logic write_strobe;
  logic read_strobe;
  logic [2:0] arm_count;
  logic [2:0] stall_count;
  logic [13:0] rc_count;
  logic rc_tick;
  nvmac_state_t state;
  nvmac_state_t next_state;
  nvmac_array_req_t pending;

  function automatic logic hit(input logic [1:0] ofs);
    hit = bus_req.wr && (bus_req.addr == ofs);
  endfunction : hit

  // ==========================================================
  // Decode
  wire busy = (state == NVMAC_WRITING);
  wire [9:0] nvm_address = {nvm_address_high, nvm_address_low};
  wire ctl_wr = hit(`NVMAC_OFS_CONTROL);
  wire wr_arm = ctl_wr && bus_req.wdata[`NVMAC_BIT_ARM];
  wire wr_strobe = ctl_wr && bus_req.wdata[`NVMAC_BIT_WRITE];
  // Strobe only counts while arm is live and flash idle
  wire start_write = wr_strobe && master_write_arm && !busy
    && !self_program_enable;
  wire start_read = ctl_wr && bus_req.wdata[`NVMAC_BIT_READ]
    && !busy;
  wire addr_wr_ok = !busy;
  wire [13:0] rc_limit = 14'(WRITE_RC_CYCLES - 1);

  nvmac_rc_tick #(
    .DIV(RC_DIV)
  ) u_rc_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tick(rc_tick)
  );

  // ==========================================================
  // Write sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      NVMAC_IDLE: begin
        if (start_write) begin
          next_state = NVMAC_WRITING;
        end
      end
      NVMAC_WRITING: begin
        if (rc_tick && rc_count == rc_limit) begin
          next_state = NVMAC_DONE;
        end
      end
      NVMAC_DONE: begin
        next_state = NVMAC_IDLE;
      end
      default: begin
        next_state = NVMAC_IDLE;
      end
    endcase
  end

  // Reset drops the sequencer state; the pending byte still lands
  // because the commit below is not gated by reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= NVMAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_count <= '0;
    end else if (!busy) begin
      rc_count <= '0;
    end else if (rc_tick) begin
      rc_count <= rc_count + 14'h1;
    end
  end

  // ==========================================================
  // Array commit
  // Reset drops the sequencer, so a byte whose timed write was cut
  // short lands at the first edge while reset is held, or at the first edge after release if none comes, instead of being lost
  logic rst_flush;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_flush <= 1'b1;
    end else begin
      rst_flush <= 1'b0;
    end
  end

  // Limitation: the cut write is taken as complete at once after reset
  wire flush_commit = rst_flush && !busy;
  wire done_commit = (state == NVMAC_DONE);
  wire commit_now = pending.we && (done_commit || flush_commit);

  // Pending byte is dropped once stored so a later reset repeats nothing
  always_ff @(posedge core_clk) begin
    if (start_write) begin
      pending <= '{addr: nvm_address, data: nvm_data_byte, we: 1'b1};
    end else if (commit_now) begin
      pending.we <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (commit_now) begin
      mem[pending.addr] <= pending.data;
    end
  end

  // ==========================================================
  // Address and data registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_address_high <= '0;
      nvm_address_low <= '0;
    end else if (addr_wr_ok) begin
      if (hit(`NVMAC_OFS_ADDR_HIGH)) begin
        nvm_address_high <= bus_req.wdata[`NVMAC_ADDR_HIGH_BITS-1:0];
      end
      if (hit(`NVMAC_OFS_ADDR_LOW)) begin
        nvm_address_low <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_data_byte <= '0;
    end else if (start_read) begin
      nvm_data_byte <= mem[nvm_address];
    end else if (hit(`NVMAC_OFS_DATA)) begin
      nvm_data_byte <= bus_req.wdata;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_irq_enable <= 1'b0;
    end else if (ctl_wr) begin
      ready_irq_enable <= bus_req.wdata[`NVMAC_BIT_RIE];
    end
  end

  // A control write carrying both arm and strobe opens no window,
  // so one write can never both arm and fire
  wire arm_load = wr_arm && !bus_req.wdata[`NVMAC_BIT_WRITE];
  wire arm_live = (arm_count != 3'h0);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_count <= '0;
    end else if (arm_load) begin
      arm_count <= `NVMAC_ARM_CYCLES;
    end else if (arm_live) begin
      arm_count <= arm_count - 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_write_arm <= 1'b0;
    end else if (arm_load) begin
      master_write_arm <= 1'b1;
    end else if (arm_live) begin
      master_write_arm <= (arm_count != 3'h1);
    end else begin
      master_write_arm <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      write_strobe <= 1'b0;
    end else if (start_write) begin
      write_strobe <= 1'b1;
    end else if (next_state == NVMAC_DONE) begin
      write_strobe <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      read_strobe <= 1'b0;
    end else begin
      read_strobe <= 1'b0;
    end
  end

  // ==========================================================
  // Processor stall
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_count <= '0;
    end else if (start_read) begin
      stall_count <= `NVMAC_READ_STALL;
    end else if (start_write) begin
      stall_count <= `NVMAC_WRITE_STALL;
    end else if (stall_count != 3'h0) begin
      stall_count <= stall_count - 3'h1;
    end
  end
  assign cpu_stall = (stall_count != 3'h0);

  // ==========================================================
  // Read path and interrupt
  wire [7:0] ctl_value = {4'h0, ready_irq_enable, master_write_arm,
    write_strobe, read_strobe};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= '0;
    end else begin
      unique case (bus_req.addr)
        `NVMAC_OFS_ADDR_HIGH: begin
          bus_rdata <= {6'h0, nvm_address_high};
        end
        `NVMAC_OFS_ADDR_LOW: begin
          bus_rdata <= nvm_address_low;
        end
        `NVMAC_OFS_DATA: begin
          bus_rdata <= nvm_data_byte;
        end
        `NVMAC_OFS_CONTROL: begin
          bus_rdata <= ctl_value;
        end
      endcase
    end
  end

  // Level request, not a pulse, so it repeats until masked
  assign ready_irq = ready_irq_enable && global_irq_enable
    && !write_strobe;
endmodule : nvmac_unit
`default_nettype wire

// file: bench/nvmac_unit_props.sv
// Checker of the access unit port behaviour
`default_nettype none
module nvmac_props
  import nvmac_pkg::*;
#(
  parameter int unsigned WRITE_RC_CYCLES = 4,
  parameter int unsigned RC_DIV = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire nvmac_pkg::nvmac_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  // Status and control
  input wire logic global_irq_enable,
  input wire logic self_program_enable,
  input wire logic cpu_stall,
  input wire logic ready_irq
);
  // ==========
  // Arm window and busy trackers
  logic [2:0] arm_cnt;
  int unsigned busy;
  wire logic ctl_wr = bus_req.wr && bus_req.addr == 2'h3;
  wire logic go = ctl_wr && bus_req.wdata == 8'h02 && arm_cnt != 3'h0;
  // Busy is generous so a late finish never arms a false check
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_cnt <= 3'h0;
      busy <= 32'h0;
    end else begin
      arm_cnt <= (ctl_wr && bus_req.wdata == 8'h04) ? 3'h4 :
        arm_cnt - 3'(arm_cnt != 3'h0);
      busy <= (go && !self_program_enable) ? WRITE_RC_CYCLES * RC_DIV + 4 :
        busy - 32'(busy != 32'h0);
    end
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // ==========
  // Port relations
  a_irq_gate: assert property (ready_irq |-> global_irq_enable)
    else $error("irq without global enable");
  a_irq_level: assert property (
    ready_irq && !bus_req.wr ##1 global_irq_enable |-> ready_irq)
    else $error("irq dropped");
  a_read_stall: assert property (
    ctl_wr && bus_req.wdata == 8'h01 && busy == 32'h0
    |=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall bad");
  a_write_stall: assert property (
    go && !self_program_enable && busy == 32'h0
    |=> cpu_stall [*2] ##1 !cpu_stall) else $error("write stall bad");
  a_no_arm: assert property (
    ctl_wr && bus_req.wdata[1] && !bus_req.wdata[0] && arm_cnt == 3'h0
    && !cpu_stall
    |=> !cpu_stall) else $error("unarmed strobe acted");
  a_flash_lock: assert property (
    ctl_wr && bus_req.wdata[1] && !bus_req.wdata[0] && self_program_enable
    && !cpu_stall
    |=> !cpu_stall) else $error("write during flash busy");
  a_ctl_zero: assert property (
    bus_req.addr == 2'h3 |=> bus_rdata[7:4] == 4'h0 && !bus_rdata[0])
    else $error("control zero bits set");
  a_addr_high: assert property (
    bus_req.addr == 2'h0 |=> bus_rdata[7:2] == 6'h00)
    else $error("address high bits set");
endmodule : nvmac_props
`default_nettype wire

// file: bench/nvmac_unit_tb.sv
// Self-checking bench of the access unit
`default_nettype none
module nvmac_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nvmac_pkg::*;
  // ==========
  // Signals and unit
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic gie = 1'b1;
  logic spe = 1'b0;
  logic vld = 1'b0;
  nvmac_bus_req_t req = '0;
  logic [7:0] bus_rdata;
  logic cpu_stall;
  logic ready_irq;
  logic [7:0] exq[$];
  string nmq[$];
  int stq[$];
  int fails = 0;
  int n_tests = 0;
  int scnt = 0;
  int cyc = 0;
  nvmac_unit #(.WRITE_RC_CYCLES(4), .RC_DIV(2)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .bus_req(req),
    .bus_rdata(bus_rdata), .global_irq_enable(gie),
    .self_program_enable(spe), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq));
  initial forever #5 core_clk = ~core_clk;
  // ==========
  // Bus tasks and compares
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic ck(logic [1:0] a, logic [7:0] e, string n);
    exq.push_back(e);
    nmq.push_back(n);
    @(posedge core_clk);
    req.addr <= a;
    vld <= 1'b1;
    @(posedge core_clk);
    vld <= 1'b0;
  endtask : ck
  task automatic idle();
    int k = 0;
    do begin
      @(posedge core_clk);
      req.addr <= 2'h3;
      @(posedge core_clk);
      #1;
      k++;
    end while (bus_rdata[1] !== 1'b0 && k < 100);
  endtask : idle
  // No interrupt is taken between arm and strobe
  task automatic wbyte(logic [9:0] a, logic [7:0] d);
    wr(2'h0, {6'h00, a[9:8]});
    wr(2'h1, a[7:0]);
    wr(2'h2, d);
    wr(2'h3, 8'h04);
    stq.push_back(2);
    wr(2'h3, 8'h02);
  endtask : wbyte
  task automatic rbyte(logic [9:0] a, logic [7:0] d);
    wr(2'h0, {6'h00, a[9:8]});
    wr(2'h1, a[7:0]);
    wr(2'h2, ~d);
    stq.push_back(4);
    wr(2'h3, 8'h01);
    ck(2'h2, d, "data");
  endtask : rbyte
  task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : cmp8
  task automatic cmpn(int e, int g);
    n_tests++;
    if (g != e) begin
      fails++;
      $display("Error stall exp %0d got %0d", e, g);
    end
  endtask : cmpn
  task automatic end_sim();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // ==========
  // Monitors and timeout
  always @(posedge core_clk) begin
    if (vld) begin
      #1;
      cmp8(nmq.pop_front(), exq.pop_front(), bus_rdata);
    end
  end
  always @(posedge core_clk) begin
    if (cpu_stall === 1'b1) scnt++;
    else if (scnt != 0) begin
      cmpn(stq.pop_front(), scnt);
      scnt = 0;
    end
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end
  // ==========
  // Main sequence
  initial begin
    logic [9:0] a;
    logic [7:0] d;
    void'($urandom(32'hF8C7));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    wr(2'h3, 8'h04);
    ck(2'h3, 8'h04, "arm");
    repeat (4) @(posedge core_clk);
    ck(2'h3, 8'h00, "arm clear");
    wr(2'h3, 8'h02);
    ck(2'h3, 8'h00, "no arm");
    spe <= 1'b1;
    wr(2'h3, 8'h04);
    wr(2'h3, 8'h02);
    repeat (5) @(posedge core_clk);
    ck(2'h3, 8'h00, "flash lock");
    spe <= 1'b0;
    $display("test arm done");
    for (int i = 0; i < 3; i++) begin
      a = 10'($urandom);
      d = 8'($urandom);
      wbyte(a, d);
      ck(2'h3, 8'h06, "busy");
      idle();
      rbyte(a, d);
      ck(2'h0, {6'h00, a[9:8]}, "addr high");
    end
    $display("test data done");
    wbyte(10'h3FF, 8'hA5);
    wr(2'h3, 8'h01);
    wr(2'h1, 8'h00);
    idle();
    ck(2'h2, 8'hA5, "read ignored");
    ck(2'h1, 8'hFF, "addr lock");
    $display("test busy done");
    wr(2'h3, 8'h08);
    ck(2'h3, 8'h08, "irq enable");
    #1;
    cmp8("irq on", 8'h01, {7'h00, ready_irq});
    gie <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    cmp8("irq masked", 8'h00, {7'h00, ready_irq});
    gie <= 1'b1;
    repeat (3) @(posedge core_clk);
    $display("test irq done");
    wbyte(10'h155, 8'h3C);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    rst_b <= 1'b1;
    rbyte(10'h155, 8'h3C);
    $display("test reset done");
    end_sim();
  end
endmodule : nvmac_unit_tb
bind nvmac_unit nvmac_props #(.WRITE_RC_CYCLES(WRITE_RC_CYCLES),
  .RC_DIV(RC_DIV)) u_props (.core_clk(core_clk), .rst_b(rst_b),
  .bus_req(bus_req), .bus_rdata(bus_rdata),
  .global_irq_enable(global_irq_enable),
  .self_program_enable(self_program_enable), .cpu_stall(cpu_stall),
  .ready_irq(ready_irq));
`default_nettype wire
